// ---- rtl/eap_pkg.sv ----
package eap_pkg;

  // ----------------------------------------------------------------
  // Sizes and address map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 8;
  localparam int          SRAM_BYTES    = 64;
  localparam int          DEE_BYTES     = 64;
  localparam int          CODE_BYTES    = 1024;
  localparam logic [11:0] SRAM_LO       = 12'h000;
  localparam logic [11:0] SRAM_HI       = 12'h03f;
  localparam logic [11:0] DEE_LO        = 12'h040;
  localparam logic [11:0] DEE_HI        = 12'h07f;
  localparam logic [11:0] DEE_UPPER_LO  = 12'h060;
  localparam logic [11:0] STATUS_ADDR   = 12'h0cf;
  localparam logic [11:0] CODE_LO       = 12'hc00;
  localparam logic [11:0] CODE_HI       = 12'hfff;
  localparam logic [11:0] CFG1_ADDR     = 12'h7fe;
  localparam logic [11:0] CFG2_ADDR     = 12'h7ff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_READ_LOCK     = 0;
  localparam int CFG_WRITE_LOCK    = 1;
  localparam int CFG_UPPER_PROTECT = 2;
  localparam int CFG_BROWNOUT_LVL  = 3;
  localparam int CFG_BROWNOUT_EN   = 4;
  localparam int CFG_WATCHDOG_EN   = 5;
  localparam int CFG_CLK_SEL1      = 6;
  localparam int CFG_CLK_SEL0      = 7;
  localparam int STATUS_READY_BIT  = 0;

  // ----------------------------------------------------------------
  // Reset and factory values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG1_FACTORY   = 8'h00;
  localparam logic [7:0] CFG2_FACTORY   = 8'h80;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 25;
  localparam int EE_WRITE_TIME_US  = 10;
  localparam int EE_WRITE_CYCLES   = EE_WRITE_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EAP_ST_LOAD = 2'b01,
    EAP_ST_RUN  = 2'b10
  } eap_state_t;

  typedef struct packed {
    eap_state_t  state;
    logic        prog_meta;
    logic        prog_sync;
    logic        prog;
    logic [7:0]  nv_cfg1;
    logic [7:0]  nv_cfg2;
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  status;
    logic [7:0]  rdata;
    logic        rd_valid;
    logic        rd_refused;
    logic        wr_refused;
  } eap_regs_t;

endpackage : eap_pkg

// ---- rtl/eap_ee_timer.sv ----
`timescale 1ns/1ps
module eap_ee_timer
  import eap_pkg::*;
#(
  parameter int CYCLES = EE_WRITE_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      ready_o
);

  // ----------------------------------------------------------------
  // Write cycle counter
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  logic [CNT_W-1:0] count_r;

  // Start is only honoured while idle so a cycle cannot be stretched
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_r <= '0;
      ready_o <= 1'b1;
    end else if (start_i && ready_o) begin
      count_r <= CNT_LOAD;
      ready_o <= 1'b0;
    end else if (!ready_o) begin
      if (count_r == CNT_ONE) begin
        ready_o <= 1'b1;
      end
      count_r <= count_r - CNT_ONE;
    end
  end

endmodule : eap_ee_timer

// ---- rtl/eap_mem_ctrl.sv ----
`timescale 1ns/1ps
module eap_mem_ctrl
  import eap_pkg::*;
#(
  parameter int         EE_CYCLES    = EE_WRITE_CYCLES,
  parameter logic [7:0] CFG1_DEFAULT = CFG1_FACTORY,
  parameter logic [7:0] CFG2_DEFAULT = CFG2_FACTORY
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              prog_pin_i,
  input  wire logic [ADDR_W-1:0] cpu_addr_i,
  input  wire logic [DATA_W-1:0] cpu_wdata_i,
  input  wire logic              cpu_rd_i,
  input  wire logic              cpu_wr_i,
  output logic [DATA_W-1:0]      cpu_rdata_o,
  output logic                   cpu_rvalid_o,
  output logic                   rd_refused_o,
  output logic                   wr_refused_o,
  output logic                   ee_ready_o,
  output logic                   prog_mode_o,
  output logic                   cfg_valid_o,
  output logic [1:0]             clock_source_select_o,
  output logic                   watchdog_enable_o,
  output logic                   brownout_enable_o,
  output logic                   brownout_level_select_o,
  output logic [7:0]             osc_trim_o
);

  // ----------------------------------------------------------------
  // Address decoding helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // ----------------------------------------------------------------
  // Storage arrays
  // ----------------------------------------------------------------
  // memory sizes
  logic [7:0] sram_mem [SRAM_BYTES];
  logic [7:0] dee_mem  [DEE_BYTES];
  logic [7:0] code_mem [CODE_BYTES];

  eap_regs_t  q_r;
  eap_regs_t  q_nxt;

  logic       ee_ready;
  logic       hit_sram;
  logic       hit_dee;
  logic       hit_code;
  logic       hit_status;
  logic       hit_cfg1;
  logic       hit_cfg2;
  logic       hit_upper;
  logic       running;
  logic       rd_ok;
  logic       wr_ok;
  logic       sram_we;
  logic       dee_we;
  logic       code_we;
  logic [7:0] read_mux;
  logic [7:0] status_view;
  logic       both_locks;

  // Region decode of the incoming address
  always_comb begin
    hit_sram   = in_range(cpu_addr_i, SRAM_LO, SRAM_HI);
    hit_dee    = in_range(cpu_addr_i, DEE_LO, DEE_HI);
    hit_code   = in_range(cpu_addr_i, CODE_LO, CODE_HI);
    hit_upper  = in_range(cpu_addr_i, DEE_UPPER_LO, DEE_HI);
    hit_status = (cpu_addr_i == STATUS_ADDR);
    hit_cfg1   = (cpu_addr_i == CFG1_ADDR);
    hit_cfg2   = (cpu_addr_i == CFG2_ADDR);
  end

  // ----------------------------------------------------------------
  // Access permission
  // ----------------------------------------------------------------
  assign running    = (q_r.state == EAP_ST_RUN);
  assign both_locks = q_r.cfg1[CFG_READ_LOCK] && q_r.cfg1[CFG_WRITE_LOCK];

  // Reads are refused only in program mode with the read lock set
  always_comb begin
    rd_ok = running && !(q_r.prog && q_r.cfg1[CFG_READ_LOCK]);
    wr_ok = running && !(q_r.prog && q_r.cfg1[CFG_WRITE_LOCK]);
  end

  // Per-array write enables
  always_comb begin
    sram_we = 1'b0;
    dee_we  = 1'b0;
    code_we = 1'b0;
    if (cpu_wr_i && wr_ok) begin
      sram_we = hit_sram;
      dee_we  = hit_dee && ee_ready &&
                !(hit_upper && q_r.cfg1[CFG_UPPER_PROTECT]);
      code_we = hit_code && q_r.prog;
    end
  end

  // Ready flag sits in its own bit; the rest of the byte is plain storage
  always_comb begin
    status_view                   = q_r.status;
    status_view[STATUS_READY_BIT] = ee_ready;
  end

  // Read data multiplexer; unmapped addresses read as zero
  always_comb begin
    read_mux = READ_ZERO;
    if (hit_sram) begin
      read_mux = sram_mem[cpu_addr_i[5:0]];
    end else if (hit_dee) begin
      read_mux = dee_mem[cpu_addr_i[5:0]];
    end else if (hit_code) begin
      read_mux = code_mem[cpu_addr_i[9:0]];
    end else if (hit_status) begin
      read_mux = status_view;
    end else if (hit_cfg1 && q_r.prog) begin
      read_mux = q_r.nv_cfg1;
    end else if (hit_cfg2 && q_r.prog) begin
      read_mux = q_r.nv_cfg2;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt            = q_r;
    q_nxt.rd_valid   = 1'b0;
    q_nxt.rd_refused = 1'b0;
    q_nxt.wr_refused = 1'b0;

    // Program pin crosses in from outside, so it is synchronised first
    q_nxt.prog_meta = prog_pin_i;
    q_nxt.prog_sync = q_r.prog_meta;

    case (q_r.state)
      EAP_ST_LOAD: begin
        q_nxt.cfg1  = q_r.nv_cfg1;
        q_nxt.cfg2  = q_r.nv_cfg2;
        q_nxt.state = EAP_ST_RUN;
      end
      EAP_ST_RUN: begin
        q_nxt.prog = q_r.prog_sync && !both_locks;

        if (cpu_rd_i) begin
          q_nxt.rd_valid   = 1'b1;
          q_nxt.rdata      = rd_ok ? read_mux : READ_ZERO;
          q_nxt.rd_refused = !rd_ok;
        end

        if (cpu_wr_i) begin
          if (!wr_ok) begin
            q_nxt.wr_refused = 1'b1;
          end else if (hit_status) begin
            // Ready bit is hardware owned and ignores stores
            q_nxt.status                   = cpu_wdata_i;
            q_nxt.status[STATUS_READY_BIT] = 1'b0;
          end else if (hit_cfg1 && q_r.prog) begin
            q_nxt.nv_cfg1 = cpu_wdata_i;
            q_nxt.cfg1    = cpu_wdata_i;
          end else if (hit_cfg2 && q_r.prog) begin
            q_nxt.nv_cfg2 = cpu_wdata_i;
            q_nxt.cfg2    = cpu_wdata_i;
          end else if (!(sram_we || dee_we || code_we)) begin
            // Blocked or unmapped store leaves every array untouched
            q_nxt.wr_refused = 1'b1;
          end
        end
      end
      default: begin
        q_nxt.state = EAP_ST_LOAD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset stands for power-up, so the cells return to their CFG1_DEFAULT and CFG2_DEFAULT values
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_r.state      <= EAP_ST_LOAD;
      q_r.prog_meta  <= 1'b0;
      q_r.prog_sync  <= 1'b0;
      q_r.prog       <= 1'b0;
      q_r.nv_cfg1    <= CFG1_DEFAULT;
      q_r.nv_cfg2    <= CFG2_DEFAULT;
      q_r.cfg1       <= CFG1_FACTORY;
      q_r.cfg2       <= CFG2_FACTORY;
      q_r.status     <= STATUS_RESET;
      q_r.rdata      <= READ_ZERO;
      q_r.rd_valid   <= 1'b0;
      q_r.rd_refused <= 1'b0;
      q_r.wr_refused <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Memory arrays
  // ----------------------------------------------------------------
  // Arrays carry no reset; contents survive rst_i like real cells would
  always_ff @(posedge ref_clk_i) begin
    if (sram_we) begin
      sram_mem[cpu_addr_i[5:0]] <= cpu_wdata_i;
    end
    if (dee_we) begin
      dee_mem[cpu_addr_i[5:0]] <= cpu_wdata_i;
    end
    if (code_we) begin
      code_mem[cpu_addr_i[9:0]] <= cpu_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Data EEPROM write cycle timer
  // ----------------------------------------------------------------
  eap_ee_timer #(
    .CYCLES (EE_CYCLES)
  ) u_ee_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (dee_we),
    .ready_o   (ee_ready)
  );

  // ----------------------------------------------------------------
  // Outputs, taken straight from flip-flops except cfg_valid_o, which is decoded from the state
  // ----------------------------------------------------------------
  assign cpu_rdata_o  = q_r.rdata;
  assign cpu_rvalid_o = q_r.rd_valid;
  assign rd_refused_o = q_r.rd_refused;
  assign wr_refused_o = q_r.wr_refused;
  assign ee_ready_o   = ee_ready;
  assign prog_mode_o  = q_r.prog;
  assign cfg_valid_o  = running;

  assign clock_source_select_o   = {q_r.cfg1[CFG_CLK_SEL1], q_r.cfg1[CFG_CLK_SEL0]};
  assign watchdog_enable_o       = q_r.cfg1[CFG_WATCHDOG_EN];
  assign brownout_enable_o       = q_r.cfg1[CFG_BROWNOUT_EN];
  assign brownout_level_select_o = q_r.cfg1[CFG_BROWNOUT_LVL];
  assign osc_trim_o              = q_r.cfg2;

endmodule : eap_mem_ctrl

// ---- verif/eap_mem_ctrl_asserts.sv ----
`timescale 1ns/1ps
module eap_mem_ctrl_asserts
  import eap_pkg::*;
#(
  parameter int EE_CYCLES = 8
) (
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic              prog_pin_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic              cpu_rd_i,
  input wire logic              cpu_wr_i,
  input wire logic [DATA_W-1:0] cpu_rdata_o,
  input wire logic              cpu_rvalid_o,
  input wire logic              rd_refused_o,
  input wire logic              wr_refused_o,
  input wire logic              ee_ready_o,
  input wire logic              prog_mode_o,
  input wire logic              cfg_valid_o,
  input wire logic [7:0]        osc_trim_o
);
  // ----------------------------------------------------------------
  // Bus relations
  // ----------------------------------------------------------------
  localparam int EE_M1 = EE_CYCLES - 1;
  logic dee;
  logic dee_lo;
  logic req_w;
  // Address decode kept apart so the properties stay short
  assign dee    = cpu_addr_i >= DEE_LO && cpu_addr_i <= DEE_HI;
  assign dee_lo = cpu_addr_i >= DEE_LO && cpu_addr_i < DEE_UPPER_LO;
  assign req_w  = cpu_wr_i && cfg_valid_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_read_answer: assert property (
    cpu_rd_i && cfg_valid_o |=> cpu_rvalid_o) else $error("read not answered");
  chk_read_refuse: assert property (
    rd_refused_o |-> $past(prog_mode_o) && cpu_rdata_o == 8'h00) else $error("bad refusal");
  chk_ee_launch: assert property (
    req_w && ee_ready_o && dee_lo && !prog_mode_o |=> !ee_ready_o)
    else $error("store did not start");
  chk_ee_length: assert property (
    $fell(ee_ready_o) |-> ##EE_M1 !ee_ready_o ##1 ee_ready_o) else $error("busy length");
  chk_busy_drop: assert property (
    req_w && !ee_ready_o && dee |=> wr_refused_o) else $error("busy store kept");
  chk_code_block: assert property (
    req_w && !prog_mode_o && cpu_addr_i >= CODE_LO |=> wr_refused_o)
    else $error("code write let through");
  chk_status_ready: assert property (
    cpu_rd_i && cfg_valid_o && !prog_mode_o && cpu_addr_i == STATUS_ADDR |=>
    cpu_rdata_o[0] == $past(ee_ready_o)) else $error("status ready bit");
  chk_prog_entry: assert property (
    $rose(prog_mode_o) |-> $past(prog_pin_i, 3)) else $error("prog entry timing");
  chk_trim_hold: assert property (
    cfg_valid_o && !prog_mode_o |=> $stable(osc_trim_o)) else $error("trim moved");
  // Main scenarios reached
  cov_ee_write: cover property ($fell(ee_ready_o));
  cov_prog: cover property ($rose(prog_mode_o));
  cov_refuse: cover property (wr_refused_o);
endmodule : eap_mem_ctrl_asserts

bind eap_mem_ctrl eap_mem_ctrl_asserts #(.EE_CYCLES(EE_CYCLES)) u_chk (
  .ref_clk_i, .rst_i, .prog_pin_i, .cpu_addr_i, .cpu_rd_i, .cpu_wr_i, .cpu_rdata_o,
  .cpu_rvalid_o, .rd_refused_o, .wr_refused_o, .ee_ready_o, .prog_mode_o,
  .cfg_valid_o, .osc_trim_o);

// ---- verif/eap_cpu_model.sv ----
`timescale 1ns/1ps
module eap_cpu_model
  import eap_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic              rd_ref_i,
  input  wire logic              wr_ref_i,
  input  wire logic              ready_i,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      wdata_o,
  output logic                   rd_o,
  output logic                   wr_o
);
  // ----------------------------------------------------------------
  // Core loads and stores
  // ----------------------------------------------------------------
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
  end
  // poll ready flag; only data EEPROM waits, status polls must pass
  task automatic poll(input logic [11:0] a);
    for (int n = 0; n < 60 && a >= DEE_LO && a <= DEE_HI && !ready_i; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask : poll
  // Bus left inverted after release so stale values never look valid
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input bit p, output logic rf);
    if (p) poll(a);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(posedge ref_clk_i);
    #1;
    wr_o    = 1'b0;
    rf      = wr_ref_i;
    addr_o  = ~a;
    wdata_o = ~d;
    @(posedge ref_clk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] q, output logic rf);
    poll(a);
    addr_o = a;
    rd_o   = 1'b1;
    @(posedge ref_clk_i);
    #1;
    rd_o   = 1'b0;
    q      = rdata_i;
    rf     = rd_ref_i;
    addr_o = ~a;
    @(posedge ref_clk_i);
    #1;
  endtask : rd
endmodule : eap_cpu_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import eap_pkg::*;
;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  localparam int EE = 8;
  // Stored config with the brown-out level bit set, so keeping it shows up
  localparam logic [7:0] CFG1_INIT = 8'h08;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic        f;
    logic        c;
    logic [7:0]  q;
  } eap_row_t;
  logic        clk = 0, rst = 1, pin = 0, rd, wr, rv, rdref, wref, rdy, pm, cval;
  logic        wdog, boren, brownout_level_select, rf;
  logic [11:0] addr;
  logic [7:0]  wdat, rdat, trim, q, c1;
  logic [1:0]  csel;
  int          failures = 0, checked = 0, cyc = 0, n;
  // Plain stores with their readback; code space reads are unknown, so skipped
  eap_row_t rows [9] = '{'{12'h000, 8'ha5, 1'b0, 1'b1, 8'ha5},
    '{12'h03f, 8'h5a, 1'b0, 1'b1, 8'h5a}, '{12'h040, 8'hc3, 1'b0, 1'b1, 8'hc3},
    '{12'h07f, 8'h3c, 1'b0, 1'b1, 8'h3c}, '{12'hc00, 8'h11, 1'b1, 1'b0, 8'h00},
    '{12'hfff, 8'h22, 1'b1, 1'b0, 8'h00}, '{12'h7fe, 8'h33, 1'b1, 1'b1, 8'h00},
    '{12'h100, 8'h44, 1'b1, 1'b1, 8'h00}, '{12'h0cf, 8'hf0, 1'b0, 1'b1, 8'hf1}};
  always #20 clk = ~clk;
  eap_mem_ctrl #(.EE_CYCLES(EE), .CFG1_DEFAULT(CFG1_INIT)) uut (.ref_clk_i(clk),
    .rst_i(rst), .prog_pin_i(pin),
    .cpu_addr_i(addr), .cpu_wdata_i(wdat), .cpu_rd_i(rd), .cpu_wr_i(wr),
    .cpu_rdata_o(rdat), .cpu_rvalid_o(rv), .rd_refused_o(rdref), .wr_refused_o(wref),
    .ee_ready_o(rdy), .prog_mode_o(pm), .cfg_valid_o(cval), .clock_source_select_o(csel),
    .watchdog_enable_o(wdog), .brownout_enable_o(boren), .brownout_level_select_o(brownout_level_select),
    .osc_trim_o(trim));
  eap_cpu_model cpu (.ref_clk_i(clk), .rdata_i(rdat), .rd_ref_i(rdref), .wr_ref_i(wref),
    .ready_i(rdy), .addr_o(addr), .wdata_o(wdat), .rd_o(rd), .wr_o(wr));
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic cy(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cy
  // Hang guard, run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cy(6);
    check("cfg_in_reset", 8'(cval), 8'h00);
    rst = 0;
    cy(2);
    check("cfg_valid", 8'(cval), 8'h01);
    check("brownout_level_select_load", 8'(brownout_level_select), 8'(CFG1_INIT[3]));
    check("trim", trim, CFG2_FACTORY);
    check("ready", 8'(rdy), 8'h01);
    cpu.rd(STATUS_ADDR, q, rf);
    check("status", q, 8'h01);
    for (int i = 0; i < 9; i++) begin
      cpu.wr(rows[i].a, rows[i].d, 1'b1, rf);
      check("wr_refused", 8'(rf), 8'(rows[i].f));
      cpu.rd(rows[i].a, q, rf);
      if (rows[i].c) check("rdata", q, rows[i].q);
    end
    // Store while busy is dropped, status shows busy
    cpu.wr(12'h041, 8'h66, 1'b1, rf);
    check("busy", 8'(rdy), 8'h00);
    cpu.wr(12'h042, 8'h77, 1'b0, rf);
    check("busy_refused", 8'(rf), 8'h01);
    cpu.rd(STATUS_ADDR, q, rf);
    check("status_busy", q, 8'hf0);
    for (n = 0; n < 40 && rdy !== 1'b1; n++) cy(1);
    check("busy_len", 8'(n), 8'(EE - 5));
    cpu.rd(12'h041, q, rf);
    check("ee_data", q, 8'h66);
    pin = 1;
    cy(4);
    check("prog", 8'(pm), 8'h01);
    cpu.wr(12'hc10, 8'h5c, 1'b1, rf);
    cpu.rd(12'hc10, q, rf);
    check("code", q, 8'h5c);
    cpu.wr(CFG2_ADDR, 8'h55, 1'b1, rf);
    check("trim_new", trim, 8'h55);
    cpu.rd(CFG2_ADDR, q, rf);
    check("cfg2_read", q, 8'h55);
    cpu.rd(CFG1_ADDR, q, rf);
    check("cfg1_read", q, CFG1_INIT);
    c1 = (q & 8'h08) | 8'hb4;
    cpu.wr(CFG1_ADDR, c1, 1'b1, rf);
    check("csel", 8'(csel), 8'h01);
    check("wdog", 8'(wdog), 8'h01);
    check("boren", 8'(boren), 8'h01);
    check("brownout_level_select", 8'(brownout_level_select), 8'(CFG1_INIT[3]));
    pin = 0;
    cy(4);
    cpu.wr(12'h060, 8'h01, 1'b1, rf);
    check("upper", 8'(rf), 8'h01);
    cpu.wr(12'h05f, 8'h01, 1'b1, rf);
    check("lower", 8'(rf), 8'h00);
    // Long enough for the lower block write to finish before any access
    pin = 1;
    cy(8);
    cpu.wr(CFG1_ADDR, c1 | 8'h01, 1'b1, rf);
    cpu.rd(12'h000, q, rf);
    check("rlock_flag", 8'(rf), 8'h01);
    check("rlock_data", q, 8'h00);
    cpu.wr(CFG1_ADDR, c1, 1'b1, rf);
    cpu.rd(12'h000, q, rf);
    check("unlock", q, 8'ha5);
    cpu.wr(CFG1_ADDR, c1 | 8'h02, 1'b1, rf);
    cpu.wr(12'h001, 8'h0f, 1'b1, rf);
    check("wlock", 8'(rf), 8'h01);
    // Second reset reloads the cells with their defaults, then lock both
    rst = 1;
    cy(6);
    check("cfg_in_reset2", 8'(cval), 8'h00);
    rst = 0;
    cy(6);
    check("trim_reload", trim, CFG2_FACTORY);
    cpu.wr(CFG1_ADDR, CFG1_INIT | 8'h03, 1'b1, rf);
    pin = 0;
    cy(4);
    pin = 1;
    cy(4);
    check("no_prog", 8'(pm), 8'h00);
    results();
  end
endmodule : testbench
